/* logic/cdg_defs.svh */
`ifndef CDG_DEFS_SVH
`define CDG_DEFS_SVH
// Oscillator period in ns and cycles at 100 MHz (50 kHz nominal)
`define CDG_OSC_PERIOD_NS 20000
`define CDG_CLK_PERIOD_NS 10
`define CDG_OSC_CYCLES (`CDG_OSC_PERIOD_NS / `CDG_CLK_PERIOD_NS)
// Tachometer pulse on time in ns, rounded down to cycles
`define CDG_TACH_ON_NS 220000
`define CDG_TACH_CYCLES (`CDG_TACH_ON_NS / `CDG_CLK_PERIOD_NS)
`define CDG_PHASES 3
`endif

/* logic/cdg_pkg.sv */
`default_nettype none
package cdg_pkg;
    typedef logic [2:0] cdg_hall_t;
    typedef logic [2:0] cdg_drive_t;
endpackage
`default_nettype wire

/* logic/cdg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cdg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    // Two stages; only the second stage is read outside
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule // cdg_sync
`default_nettype wire

/* logic/cdg_guard.sv */
// Notes on behaviour
// - Decode shaft inputs and registered direction into phase drives.
// - Direction latched, then shifted through two stages before decoder.
// - Latch follows input only while speed is below low threshold.
// - All drives off while latch or shift register in and out differ.
// - Shift advances on oscillator tick; change lands in 1-2 periods.
// - Each direction toggle gives one tach pulse regardless of speed.
// - Comparator trip clears the PWM latch, chopping drives off.
`timescale 1ns/1ps
`default_nettype none
`include "cdg_defs.svh"
module cdg_guard import cdg_pkg::*; #(
    parameter int OSC_CYCLES = `CDG_OSC_CYCLES,
    parameter int TACH_CYCLES = `CDG_TACH_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] shaft_position_inputs_in,
    input wire logic direction_in,
    input wire logic speed_low_in,
    input wire logic pwm_trip_in,
    output logic [2:0] high_side_drive_out,
    output logic [2:0] low_side_drive_out,
    output logic tach_out,
    output logic osc_tick_out
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] hall_s;
    logic dir_s;
    logic slow_s;
    logic trip_s;
    cdg_sync #(.WIDTH(6)) u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({shaft_position_inputs_in, direction_in, speed_low_in,
                   pwm_trip_in}),
        .sync_out({hall_s, dir_s, slow_s, trip_s})
    );
    ////////////////////////////////////////////////////////////////////
    // Oscillator divider; a slower rate is an enable pulse
    logic [31:0] osc_cnt_ff;
    logic osc_tick;
    assign osc_tick = (osc_cnt_ff == 32'(OSC_CYCLES - 1));
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_cnt_ff <= 32'h0;
        end else if (osc_tick) begin
            osc_cnt_ff <= 32'h0;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + 32'h1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_tick_out <= 1'b0;
        end else begin
            osc_tick_out <= osc_tick;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // speed gated latch
    logic dir_latch_ff;
    logic dir_latch_q;
    assign dir_latch_q = dir_latch_ff;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_latch_ff <= 1'b0;
        end else if (slow_s) begin
            dir_latch_ff <= dir_s;
        end
    end
    logic [1:0] dir_shift_ff;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_shift_ff <= 2'h0;
        end else if (osc_tick) begin
            dir_shift_ff <= {dir_shift_ff[0], dir_latch_q};
        end
    end
    logic inhibit;
    assign inhibit = (dir_s != dir_latch_q) ||
                     (dir_latch_q != dir_shift_ff[1]) ||
                     (dir_shift_ff[0] != dir_shift_ff[1]);
    ////////////////////////////////////////////////////////////////////
    // chop latch, trip wins over the period set
    logic pwm_latch_ff;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwm_latch_ff <= 1'b0;
        end else if (trip_s) begin
            pwm_latch_ff <= 1'b0;
        end else if (osc_tick) begin
            pwm_latch_ff <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // six step decode; invalid codes give no drive
    logic [2:0] nxt_high;
    logic [2:0] nxt_low;
    always_comb begin
        nxt_high = 3'h0;
        nxt_low = 3'h0;
        case (hall_s)
            3'h1: begin
                nxt_high = 3'h1;
                nxt_low = 3'h2;
            end
            3'h3: begin
                nxt_high = 3'h1;
                nxt_low = 3'h4;
            end
            3'h2: begin
                nxt_high = 3'h2;
                nxt_low = 3'h4;
            end
            3'h6: begin
                nxt_high = 3'h2;
                nxt_low = 3'h1;
            end
            3'h4: begin
                nxt_high = 3'h4;
                nxt_low = 3'h1;
            end
            3'h5: begin
                nxt_high = 3'h4;
                nxt_low = 3'h2;
            end
            default: begin
                nxt_high = 3'h0;
                nxt_low = 3'h0;
            end
        endcase
        // Reverse direction swaps the high and low phase sets
        if (dir_shift_ff[1]) begin
            {nxt_high, nxt_low} = {nxt_low, nxt_high};
        end
        if (inhibit || !pwm_latch_ff) begin
            nxt_high = 3'h0;
            nxt_low = 3'h0;
        end
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            high_side_drive_out <= 3'h0;
            low_side_drive_out <= 3'h0;
        end else begin
            high_side_drive_out <= nxt_high;
            low_side_drive_out <= nxt_low;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // tach pulse on every direction edge or shaft edge
    logic dir_prev_ff;
    logic [2:0] hall_prev_ff;
    logic [31:0] tach_cnt_ff;
    logic tach_fire;
    assign tach_fire = (dir_s != dir_prev_ff) || (hall_s != hall_prev_ff);
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_prev_ff <= 1'b0;
            hall_prev_ff <= 3'h0;
        end else begin
            dir_prev_ff <= dir_s;
            hall_prev_ff <= hall_s;
        end
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tach_cnt_ff <= 32'h0;
            tach_out <= 1'b0;
        end else if (tach_fire) begin
            tach_cnt_ff <= 32'(TACH_CYCLES - 1);
            tach_out <= 1'b1;
        end else if (tach_cnt_ff != 32'h0) begin
            tach_cnt_ff <= tach_cnt_ff - 32'h1;
        end else begin
            tach_out <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_dir_edge;
        dir_s != dir_prev_ff;
    endsequence
    a_inhibit_drives: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) inhibit |=> (high_side_drive_out == 3'h0
        && low_side_drive_out == 3'h0)) else $error("drive during change");
    a_trip_chops: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) trip_s |=> ##1 (high_side_drive_out == 3'h0))
        else $error("drive after trip");
    a_trip_chops_low: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) trip_s |=> ##1 (low_side_drive_out == 3'h0))
        else $error("low drive after trip");
    a_latch_holds: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) !slow_s |=> $stable(dir_latch_ff))
        else $error("latch moved at speed");
    a_latch_follows: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) slow_s |=> dir_latch_ff == $past(dir_s))
        else $error("latch not transparent");
    a_shift_tick: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) !osc_tick |=> $stable(dir_shift_ff))
        else $error("shift without tick");
    a_tick_out: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) osc_tick |=> osc_tick_out)
        else $error("tick output missed");
    a_shift_path: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) osc_tick |=> dir_shift_ff[1] ==
        $past(dir_shift_ff[0])) else $error("shift order wrong");
    a_shift_first: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) osc_tick |=> dir_shift_ff[0] ==
        $past(dir_latch_q)) else $error("first stage missed latch");
    a_tach_pulse: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) s_dir_edge |=> tach_out)
        else $error("no tach pulse on toggle");
    // pulse ends when count runs out
    a_tach_ends: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) (tach_out && tach_cnt_ff == 32'h0 &&
        !tach_fire) |=> !tach_out) else $error("tach pulse stuck");
    a_period_set: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) (osc_tick && !trip_s) |=> pwm_latch_ff)
        else $error("latch not set at period");
    a_decode_valid: assert property (@(posedge ref_clk_in)
        disable iff (!reset_n_in) (high_side_drive_out & low_side_drive_out)
        == 3'h0) else $error("phase shorted");
endmodule // cdg_guard
`default_nettype wire

/* verif/cdg_hall_src.sv */
`timescale 1ns/1ps
`default_nettype none
module cdg_hall_src import cdg_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic step_in,
    output var cdg_hall_t hall_out
);
    localparam cdg_hall_t SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int pos_ff = 0;
    always_ff @(posedge ref_clk_in) begin
        if (step_in) begin
            pos_ff <= (pos_ff + 1) % 6;
        end
    end
    assign hall_out = SEQ[pos_ff];
endmodule // cdg_hall_src
`default_nettype wire

/* verif/commutation_direction_guard_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CDG_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module commutation_direction_guard_tb_top import cdg_pkg::*;;
    localparam int OSC = 8;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic step = 1'b0, dir = 1'b0, slow = 1'b1, trip = 1'b0;
    cdg_hall_t hall;
    cdg_drive_t hi, lo, eh, el;
    logic tach, tick;
    int num_errors = 0, num_checks = 0, seed = 14, pos = 0, d = 0, i, ticks;
    // Drive tables in sensor sequence order
    int hi_f[6] = '{1, 1, 2, 2, 4, 4};
    int lo_f[6] = '{2, 4, 4, 1, 1, 2};
    always #5 ref_clk_in = ~ref_clk_in;
    cdg_hall_src cdg_hall_src_i (.ref_clk_in(ref_clk_in), .step_in(step),
        .hall_out(hall));
    cdg_guard #(.OSC_CYCLES(OSC), .TACH_CYCLES(4)) cdg_guard_i (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .shaft_position_inputs_in(hall), .direction_in(dir),
        .speed_low_in(slow), .pwm_trip_in(trip), .high_side_drive_out(hi),
        .low_side_drive_out(lo), .tach_out(tach), .osc_tick_out(tick));
    ////////////////////////////////////////////////////////////////////////
    // Waits leave 1 ns so registered outputs have landed
    task automatic go(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic step_once();
        @(posedge ref_clk_in);
        step <= 1'b1;
        pos = (pos + 1) % 6;
        @(posedge ref_clk_in);
        step <= 1'b0;
    endtask
    function automatic void model(input int off);
        eh = off ? 3'h0 : 3'(d ? lo_f[pos] : hi_f[pos]);
        el = off ? 3'h0 : 3'(d ? hi_f[pos] : lo_f[pos]);
    endfunction
    task automatic wait_tach();
        for (int k = 0; k < 10 && tach !== 1'b1; k++) go(1);
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        num_errors++;
        conclude();
    end
    initial begin
        go(5);
        reset_n_in <= 1'b1;
        repeat ($random(seed) & 3) step_once();
        for (i = 0; i < 12; i++) begin
            if (i == 6) begin
                @(posedge ref_clk_in);
                trip <= 1'b1;
                go(2 * OSC);
                model(1);
                `CDG_CHK({hi, lo}, {eh, el})
                @(posedge ref_clk_in);
                trip <= 1'b0;
                go(3 * OSC);
                model(0);
                `CDG_CHK({hi, lo}, {eh, el})
                @(posedge ref_clk_in);
                dir <= 1'b1;
                go(6);
                model(1);
                `CDG_CHK({hi, lo}, {eh, el})
                wait_tach();
                `CDG_CHK(tach, 1'b1)
                go(3 * OSC);
                d = 1;
                model(0);
                `CDG_CHK({hi, lo}, {eh, el})
            end
            step_once();
            go(3 * OSC);
            model(0);
            `CDG_CHK({hi, lo}, {eh, el})
        end
        @(posedge ref_clk_in);
        slow <= 1'b0;
        go(2);
        @(posedge ref_clk_in);
        dir <= 1'b0;
        wait_tach();
        `CDG_CHK(tach, 1'b1)
        go(4 * OSC);
        model(1);
        `CDG_CHK({hi, lo}, {eh, el})
        @(posedge ref_clk_in);
        dir <= 1'b1;
        go(3 * OSC);
        model(0);
        `CDG_CHK({hi, lo}, {eh, el})
        `CDG_CHK(tach, 1'b0)
        ticks = 0;
        repeat (4 * OSC) begin
            go(1);
            ticks += (tick === 1'b1) ? 1 : 0;
        end
        `CDG_CHK(ticks, 4)
        conclude();
    end
endmodule // commutation_direction_guard_tb_top
`default_nettype wire
